//--- rtl/ext_int_defines.svh
// register offsets, bit positions, reset values and functional notes for the external interrupt pin block
// Functional notes
// RULE1: polarity bit 5 selects falling edge/low level when 0 and rising edge/high level when 1.
// RULE2: mode bit 0 selects edge-only detection when 0 and edge-plus-level detection when 1.
// RULE3: pin-enable bit 4 turns the pin into an interrupt request input when 1 and disables it when 0.
// RULE4: while the pin is enabled a pull resistor is on, a pull-down for rising polarity, otherwise a pull-up.
// RULE5: read-only flag bit 3 is set by a qualifying pin event and software writes to it are ignored.
// RULE6: writing 1 to acknowledge bit 2 clears the flag, writing 0 does nothing, and the bit reads 0.
// RULE7: in edge-plus-level mode the flag stays or becomes set again while the pin holds its active level.
// RULE8: with interrupt-enable bit 1 set the interrupt request is high whenever the flag is set.
// RULE9: the two upper bits read as 0 and writes to them do nothing.
// RULE10: the pin passes two flip-flops before any detection logic looks at it.
// RULE11: with the pin disabled no events are taken, and reset clears all control bits and the flag.
`ifndef EXT_INT_DEFINES_SVH
`define EXT_INT_DEFINES_SVH

`define EXT_INT_STATUS_CONTROL_ADDR 12'h000
`define EXT_INT_EVENT_STATUS_ADDR   12'h004
`define EXT_INT_EVENT_MASK_ADDR     12'h008

`define EXT_INT_MODE_BIT     0
`define EXT_INT_IE_BIT       1
`define EXT_INT_ACK_BIT      2
`define EXT_INT_FLAG_BIT     3
`define EXT_INT_PE_BIT       4
`define EXT_INT_EDG_BIT      5

`define EXT_INT_CTRL_RESET   8'h00
`define EXT_INT_SYNC_RESET   1'b0

`endif

//--- rtl/ext_int_detect.sv
// edge and level qualifier for the synchronised interrupt pin
`timescale 1ns/1ps
module ext_int_detect
  import ext_int_pkg::*;
(
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // synchronised pin and control
  input  wire logic          pin_sync,
  input  wire ext_int_ctrl_t ctrl,
  // qualified event and active-level indication
  output logic               event_pulse,
  output logic               level_active
);

  logic prev_reg;
  logic active_now;
  logic active_prev;

  // previous sample runs always, so enabling onto an already active pin does not count as an edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= pin_sync;
    end
  end

  // polarity maps the pin to an active-high request
  assign active_now   = ctrl.polarity_select ? pin_sync : ~pin_sync; // see RULE1
  assign active_prev  = ctrl.polarity_select ? prev_reg : ~prev_reg; // see RULE1
  assign level_active = ctrl.pin_enable & ctrl.detect_mode & active_now; // see RULE2
  // edge always counts, level only in edge-plus-level mode
  assign event_pulse  = ctrl.pin_enable & ((active_now & ~active_prev) | level_active); // see RULE2 see RULE11

endmodule // ext_int_detect

//--- rtl/ext_int_pin_ctrl.sv
// external interrupt pin block with apb register access
`timescale 1ns/1ps
`include "ext_int_defines.svh"
module ext_int_pin_ctrl
  import ext_int_pkg::*;
(
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // external pin and pad controls
  input  wire logic        irq_pin,
  output logic             pull_enable,
  output logic             pull_down,
  // interrupt requests
  output logic             cpu_irq,
  output logic             block_irq
);

  ext_int_ctrl_t ctrl_reg;
  ext_int_pull_t pull;
  logic          flag_reg;
  logic [1:0]    status_reg;
  logic [1:0]    mask_reg;
  logic          pin_sync;
  logic          event_pulse;
  logic          level_active;
  logic          wr_en;
  logic          addr_ok;
  logic          ack_wr;
  logic          flag_set_edge;
  logic [31:0]   rdata_next;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // maps a register address to whether it exists
  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == `EXT_INT_STATUS_CONTROL_ADDR) ||
                  (a == `EXT_INT_EVENT_STATUS_ADDR) ||
                  (a == `EXT_INT_EVENT_MASK_ADDR);
  endfunction

  // status/control byte as software sees it
  function automatic logic [7:0] ctrl_byte(input ext_int_ctrl_t c, input logic f);
    logic [7:0] b;
    b = 8'h00; // upper bits and acknowledge read 0, see RULE9 see RULE6
    b[`EXT_INT_EDG_BIT]  = c.polarity_select;
    b[`EXT_INT_PE_BIT]   = c.pin_enable;
    b[`EXT_INT_FLAG_BIT] = f;
    b[`EXT_INT_IE_BIT]   = c.interrupt_enable;
    b[`EXT_INT_MODE_BIT] = c.detect_mode;
    ctrl_byte = b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin path

  ext_int_pin_sync u_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_async (irq_pin),
    .pin_sync  (pin_sync)
  );

  ext_int_detect u_detect (
    .pclk         (pclk),
    .presetn      (presetn),
    .pin_sync     (pin_sync),
    .ctrl         (ctrl_reg),
    .event_pulse  (event_pulse),
    .level_active (level_active)
  );

  // pull resistor follows enable and polarity
  assign pull.pull_enable = ctrl_reg.pin_enable;                           // see RULE4
  assign pull.pull_down   = ctrl_reg.pin_enable & ctrl_reg.polarity_select; // see RULE4
  assign pull_enable      = pull.pull_enable;
  assign pull_down        = pull.pull_down;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode, zero wait states

  assign addr_ok = addr_mapped(paddr);
  assign wr_en   = psel & penable & pwrite & addr_ok & pstrb[0];
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign ack_wr  = wr_en && (paddr == `EXT_INT_STATUS_CONTROL_ADDR) && pwdata[`EXT_INT_ACK_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // control bits

  // writable control bits, flag and upper bits ignored on write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= ext_int_ctrl_t'(`EXT_INT_CTRL_RESET); // see RULE11
    end else if (wr_en && paddr == `EXT_INT_STATUS_CONTROL_ADDR) begin
      ctrl_reg.polarity_select  <= pwdata[`EXT_INT_EDG_BIT];  // see RULE1
      ctrl_reg.pin_enable       <= pwdata[`EXT_INT_PE_BIT];   // see RULE3
      ctrl_reg.interrupt_enable <= pwdata[`EXT_INT_IE_BIT];   // see RULE8
      ctrl_reg.detect_mode      <= pwdata[`EXT_INT_MODE_BIT]; // see RULE2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request flag

  // set wins over acknowledge; active level keeps the flag in level mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= 1'b0; // see RULE11
    end else if (event_pulse || level_active) begin
      flag_reg <= 1'b1; // see RULE5 see RULE7
    end else if (ack_wr) begin
      flag_reg <= 1'b0; // see RULE6
    end
  end

  // cpu request follows flag when enabled
  assign cpu_irq = ctrl_reg.interrupt_enable & flag_reg; // see RULE8

  ////////////////////////////////////////////////////////////////////////////
  // event status and mask: bit0 pin event, bit1 acknowledge seen

  assign flag_set_edge = event_pulse & ~flag_reg;

  // sticky status, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == 0 && flag_set_edge) || (i == 1 && ack_wr)) begin
          status_reg[i] <= 1'b1;
        end else if (wr_en && paddr == `EXT_INT_EVENT_STATUS_ADDR && pwdata[i]) begin
          status_reg[i] <= 1'b0;
        end
      end
    end
  end

  // interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= 2'b00;
    end else if (wr_en && paddr == `EXT_INT_EVENT_MASK_ADDR) begin
      mask_reg <= pwdata[1:0];
    end
  end

  assign block_irq = |(status_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // read data

  // read mux
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (paddr == `EXT_INT_STATUS_CONTROL_ADDR) begin
      rdata_next[7:0] = ctrl_byte(ctrl_reg, flag_reg); // see RULE9
    end else if (paddr == `EXT_INT_EVENT_STATUS_ADDR) begin
      rdata_next[1:0] = status_reg;
    end else if (paddr == `EXT_INT_EVENT_MASK_ADDR) begin
      rdata_next[1:0] = mask_reg;
    end
  end

  // prdata registered during setup phase so it is valid in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_next;
    end
  end

endmodule // ext_int_pin_ctrl

//--- rtl/ext_int_pin_sync.sv
// two flip-flop synchroniser for the external interrupt pin
`timescale 1ns/1ps
`include "ext_int_defines.svh"
module ext_int_pin_sync (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pin in, synchronised level out
  input  wire logic pin_async,
  output logic      pin_sync
);

  logic meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= `EXT_INT_SYNC_RESET;
      pin_sync <= `EXT_INT_SYNC_RESET;
    end else begin
      meta_reg <= pin_async; // see RULE10
      pin_sync <= meta_reg;  // see RULE10
    end
  end

endmodule // ext_int_pin_sync

//--- rtl/ext_int_pkg.sv
// types shared by the external interrupt pin block
package ext_int_pkg;

  // software-written control bits of the status/control register
  typedef struct packed {
    logic polarity_select;
    logic pin_enable;
    logic interrupt_enable;
    logic detect_mode;
  } ext_int_ctrl_t;

  // pull resistor controls towards the pad
  typedef struct packed {
    logic pull_enable;
    logic pull_down;
  } ext_int_pull_t;

  // apb slave phase tracking
  typedef enum logic [1:0] {
    APB_IDLE   = 2'b00,
    APB_SETUP  = 2'b01,
    APB_ACCESS = 2'b11
  } apb_phase_t;

endpackage

//--- tb/ext_int_chk.sv
// port assertions for the external interrupt pin block
`timescale 1ns/1ps
module ext_int_chk
  import ext_int_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  // pin and outputs
  input wire logic        irq_pin,
  input wire logic        pull_enable,
  input wire logic        pull_down,
  input wire logic        cpu_irq
);
  logic          acc;
  logic          wr0;
  logic          rs0;
  ext_int_ctrl_t c;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access strobes for the control register
  assign acc = psel && penable;
  assign wr0 = acc && pwrite && pstrb[0] && paddr == 12'h000;
  assign rs0 = psel && !penable && !pwrite && paddr == 12'h000;
  // shadow of the written control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) c <= ext_int_ctrl_t'(4'h0);
    else if (wr0) c <= ext_int_ctrl_t'({pwdata[5:4], pwdata[1:0]});
  end
  ////////////////////////////////////////////////////////////////////////
  pull_dir_a: assert property (pull_down |-> pull_enable)
    else $error("pull-down without pull enable");
  pin_enable_a: assert property (wr0 |=> pull_enable == $past(pwdata[4]))
    else $error("pull enable not from pin enable");
  pull_pol_a: assert property (wr0 |=> pull_down == ($past(pwdata[5]) && $past(pwdata[4])))
    else $error("pull direction wrong");
  irq_mask_a: assert property (wr0 && !pwdata[1] |=> !cpu_irq)
    else $error("masked request raised");
  upper_zero_a: assert property (rs0 |=> prdata[31:6] == 26'h0)
    else $error("upper bits not zero");
  ack_read_a: assert property (rs0 |=> !prdata[2])
    else $error("ack bit read as one");
  no_event_a: assert property ($rose(cpu_irq) |-> $past(acc && pwrite) || $past(pull_enable)
    || $past(pull_enable, 2)) else $error("request from disabled pin");
  level_hold_a: assert property ((c.detect_mode && c.interrupt_enable && c.pin_enable
    && irq_pin == c.polarity_select) [*6] |-> cpu_irq) else $error("active level not held");
endmodule // ext_int_chk
bind ext_int_pin_ctrl ext_int_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .irq_pin(irq_pin),
  .pull_enable(pull_enable), .pull_down(pull_down), .cpu_irq(cpu_irq));

//--- tb/irq_board.sv
// board model of the interrupt pin with pad pull resolution
`timescale 1ns/1ps
module irq_board (
  // board drive
  input  wire logic drive_en,
  input  wire logic drive_val,
  // pad pull controls
  input  wire logic pull_enable,
  input  wire logic pull_down,
  // resolved pin
  output logic      irq_pin
);
  // a released pin follows the pull, else it drifts off its last level
  assign irq_pin = drive_en ? drive_val : pull_enable ? !pull_down : !drive_val;
endmodule // irq_board

//--- tb/testbench.sv
// self-checking bench for the external interrupt pin block
`timescale 1ns/1ps
module testbench;
  // bus, pin and bookkeeping
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, irq_pin, pull_enable, pull_down, cpu_irq, block_irq, err;
  logic        drv_en = 1'b1, drv_val = 1'b0;
  int          error_cnt = 0, samples_checked = 0, cyc = 0;
  ext_int_pin_ctrl u_ext_int_pin_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_pin(irq_pin), .pull_enable(pull_enable), .pull_down(pull_down),
    .cpu_irq(cpu_irq), .block_irq(block_irq));
  irq_board u_irq_board (.drive_en(drv_en), .drive_val(drv_val), .pull_enable(pull_enable),
    .pull_down(pull_down), .irq_pin(irq_pin));
  // clock and hang guard
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // expected control readback
  function automatic logic [31:0] ctrl_rb(input logic [31:0] w, input logic f);
    return {26'h0, w[5:4], f, 1'b0, w[1:0]};
  endfunction
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    cmp(what, exp, rd);
  endtask
  // drive or release the pin, then let it cross the synchroniser
  task automatic pin(input logic en, input logic v);
    @(posedge pclk);
    drv_en  <= en;
    drv_val <= v;
    repeat (5) @(posedge pclk);
  endtask
  task automatic irq(input logic e);
    @(negedge pclk);
    cmp("cpu_irq", {31'h0, e}, {31'h0, cpu_irq});
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] w;
    void'($urandom(32'hdb092457));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h000, 32'h0, "ctrl reset");
    rdc(12'h00C, 32'h0, "unmapped");
    cmp("slverr", 32'h1, {31'h0, err});
    cmp("pready", 32'h1, {31'h0, pready});
    apb(1'b1, 12'h000, 32'hFF);
    rdc(12'h000, 32'h33, "ctrl all ones");
    cmp("pulls", 32'h3, {30'h0, pull_enable, pull_down});
    pstrb <= 4'h0;
    apb(1'b1, 12'h000, 32'h0);
    pstrb <= 4'hF;
    rdc(12'h000, 32'h33, "strobe off");
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      w = {26'h0, i[1], 5'b10110} | {31'h0, i[0]};
      apb(1'b1, 12'h000, w);
      pin(1'b0, 1'b0);
      apb(1'b1, 12'h000, w);
      irq(1'b0);
      pin(1'b1, i[1]);
      irq(1'b1);
      rdc(12'h000, ctrl_rb(w, 1'b1), "flag set");
      apb(1'b1, 12'h000, w);
      irq(i[0]);
      pin(1'b0, 1'b0);
      apb(1'b1, 12'h000, w);
      irq(1'b0);
    end
    $display("test detection done");
    apb(1'b1, 12'h000, 32'h34);
    apb(1'b1, 12'h004, 32'h3);
    pin(1'b1, 1'b1);
    irq(1'b0);
    rdc(12'h000, 32'h38, "polled flag");
    rdc(12'h004, 32'h1, "event status");
    apb(1'b1, 12'h008, 32'h1);
    rdc(12'h008, 32'h1, "event mask");
    @(negedge pclk);
    cmp("block_irq", 32'h1, {31'h0, block_irq});
    apb(1'b1, 12'h004, 32'h3);
    @(negedge pclk);
    cmp("block_irq", 32'h0, {31'h0, block_irq});
    $display("test masking done");
    apb(1'b1, 12'h000, 32'h26);
    pin(1'b1, 1'b0);
    pin(1'b1, 1'b1);
    rdc(12'h000, 32'h22, "pin disabled");
    rdc(12'h004, 32'h2, "ack seen");
    $display("test disable done");
    for (int i = 0; i < 30; i++) begin
      w = $urandom;
      apb(1'b1, 12'h000, w);
      pin(1'b1, w[8]);
      apb(1'b0, 12'h000, 32'h0);
      cmp("ctrl random", ctrl_rb(w, 1'b0), rd & 32'hFFFFFFF7);
    end
    $display("test random done");
    // reset in mid-run clears control bits, flag and status
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h000, 32'h0, "ctrl after reset");
    rdc(12'h004, 32'h0, "status after reset");
    $display("test reset done");
    finish_test();
  end
endmodule // testbench
